/* logic/i2c_slave_regif.sv */
// Serial interface module as an I2C slave with an APB register file.
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Function
// (RULE1) One 8-bit data buffer carries every byte sent or received.
// (RULE2) Software loads the byte to send first and reads received ones.
// (RULE3) Slave address sits in bits 7..1; bit 0 spare, read-write; reset 0.
// (RULE4) The block is selected when a sent address equals the stored one.
// (RULE5) Slave address shares its location with SPI control register 2.
// (RULE6) Three-bit mode picks function; 110 is I2C slave; resets to 111.
// (RULE7) In SPI slave mode the outside master supplies the clock.
// (RULE8) Debounce of the clock input: none, 2 or 4 system clocks.
// (RULE9) With enable low the pins lose function and logic is held idle.
// (RULE10) Enabling I2C keeps direction and ack bits, resets the other flags; the code also keeps the wake enable.
// (RULE11) Incomplete flag only means something in SPI slave mode.
// (RULE12) Complete flag low while shifting, high after a byte, resets high.
// (RULE13) Match flag set on address equality, low otherwise.
// (RULE14) Busy flag set by START and cleared by STOP.
// (RULE15) After 8 received bits the ack bit is driven on the ninth clock.
// (RULE16) Read/write flag captures the direction bit of a matched address.
// (RULE17) Master's ninth-clock ack recorded; a NACK ends transmission.
// (RULE18) Software clears the wake enable after a match wake-up.
// (RULE19) Direction bit makes the slave transmitter or receiver.
// (RULE20) START is SDA falling, STOP SDA rising, with the clock high.
module i2c_slave_regif (
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        srst,
    // APB slave.
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // I2C pins.
    input  wire logic        sclIn,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOe,
    // Events.
    output logic             xferDone,
    output logic             wakeReq
);
    typedef struct packed {
        logic [7:0]            dataBuf;
        logic [7:0]            slaveAdr;
        logic [2:0]            mode;
        logic [1:0]            debSel;
        logic                  enable;
        logic                  icf;
        logic                  done;
        logic                  match;
        logic                  busy;
        logic                  dirTx;
        logic                  txAck;
        logic                  mstRd;
        logic                  wakeEn;
        logic                  rxAck;
        i2cs_pkg::link_state_e st;
        logic [7:0]            shift;
        logic [3:0]            bitCnt;
        logic                  fromAdr;
        logic                  sclPrev;
        logic                  sdaPrev;
        logic [31:0]           prdata;
        logic                  pready;
        logic                  pslverr;
        logic                  sdaOut;
        logic                  sdaOe;
        logic                  xferDone;
        logic                  wakeReq;
    } state_s;

    state_s       r;
    state_s       n;
    scl_filter_if flt ();

    logic         i2cOn;
    logic         sclRise;
    logic         sclFall;
    logic         startDet;
    logic         stopDet;
    logic         access;
    logic         mapped;
    logic         wrEn;
    logic [7:0]   rd8;
    logic [7:0]   byteIn;

    // ==========
    // Clock line filter.
    scl_debounce u_deb (
        .sys_clk (sys_clk),
        .srst    (srst),
        .flt     (flt)
    );

    // The filter only runs in I2C mode so it draws nothing otherwise.
    assign flt.sclRaw = sclIn;
    assign flt.debSel = r.debSel; // RULE8
    assign flt.enable = i2cOn; // RULE9

    // ==========
    // Bus events seen on the filtered clock and the data line.
    always_comb begin
        i2cOn = r.enable &&
                r.mode == i2cs_pkg::MODE_I2C_SLV; // RULE6
        sclRise = flt.sclClean & ~r.sclPrev;
        sclFall = ~flt.sclClean & r.sclPrev;
        startDet = flt.sclClean & r.sclPrev
                   & r.sdaPrev & ~sdaIn; // RULE20
        stopDet = flt.sclClean & r.sclPrev
                  & ~r.sdaPrev & sdaIn; // RULE20
        byteIn = {r.shift[6:0], sdaIn};
    end

    // ==========
    // Register decode and read data.
    always_comb begin
        access = psel & penable;
        mapped = 1'b1;
        unique case (paddr)
            i2cs_pkg::OFS_DATA: begin
                rd8 = r.dataBuf;
            end
            i2cs_pkg::OFS_SLAVE_ADR: begin
                rd8 = r.slaveAdr; // RULE5
            end
            i2cs_pkg::OFS_CTRL0: begin
                // Bit 4 is not implemented and reads zero.
                rd8 = {r.mode, 1'b0, r.debSel, r.enable, r.icf};
            end
            i2cs_pkg::OFS_STATUS: begin
                rd8 = {r.done, r.match, r.busy, r.dirTx,
                       r.txAck, r.mstRd, r.wakeEn, r.rxAck};
            end
            default: begin
                rd8 = 8'h00;
                mapped = 1'b0;
            end
        endcase
        wrEn = access & r.pready & pwrite & mapped;
    end

    // ==========
    // Next state: bus slave, register writes, then the link engine.
    always_comb begin
        n = r;
        n.xferDone = 1'b0;
        n.wakeReq = 1'b0;
        n.sdaOut = 1'b0;
        n.sclPrev = flt.sclClean;
        n.sdaPrev = sdaIn;

        // One wait state: the answer is registered so every bus
        // output comes from a flip-flop.
        if (access && !r.pready) begin
            n.pready = 1'b1;
            n.pslverr = ~mapped;
            n.prdata = {24'h000000, rd8};
        end else begin
            n.pready = 1'b0;
            n.pslverr = 1'b0;
            n.prdata = 32'h00000000;
        end

        // Writes land at the edge that completes the access.
        if (wrEn) begin
            unique case (paddr)
                i2cs_pkg::OFS_DATA: begin
                    n.dataBuf = pwdata[7:0]; // RULE2
                end
                i2cs_pkg::OFS_SLAVE_ADR: begin
                    n.slaveAdr = pwdata[7:0]; // RULE3
                end
                i2cs_pkg::OFS_CTRL0: begin
                    n.mode = pwdata[i2cs_pkg::MODE_MSB:
                                    i2cs_pkg::MODE_LSB]; // RULE6
                    n.debSel = pwdata[i2cs_pkg::DEB_MSB:
                                      i2cs_pkg::DEB_LSB];
                    n.enable = pwdata[i2cs_pkg::EN_BIT];
                    // Stored only; no logic in this block uses it.
                    n.icf = pwdata[i2cs_pkg::ICF_BIT]; // RULE11
                end
                default: begin
                    n.dirTx = pwdata[i2cs_pkg::DIR_BIT];
                    n.txAck = pwdata[i2cs_pkg::TXACK_BIT];
                    n.wakeEn = pwdata[i2cs_pkg::WAKE_BIT];
                end
            endcase
        end

        // Enabling in I2C mode resets the status flags only.
        if (!r.enable && n.enable &&
            n.mode == i2cs_pkg::MODE_I2C_SLV) begin
            n.done = 1'b1; // RULE10
            n.match = 1'b0;
            n.busy = 1'b0;
            n.mstRd = 1'b0;
            n.rxAck = 1'b1;
        end

        if (!i2cOn) begin
            // Pins released and engine parked while disabled.
            n.st = i2cs_pkg::ST_IDLE; // RULE9
            n.sdaOe = 1'b0;
        end else if (startDet) begin
            // A repeated START also restarts address reception.
            n.busy = 1'b1; // RULE14
            n.st = i2cs_pkg::ST_ADDR;
            n.bitCnt = 4'h0;
            n.done = 1'b0; // RULE12
            n.match = 1'b0;
            n.sdaOe = 1'b0;
        end else if (stopDet) begin
            n.busy = 1'b0; // RULE14
            n.match = 1'b0;
            n.st = i2cs_pkg::ST_IDLE;
            n.sdaOe = 1'b0;
        end else begin
            unique case (r.st)
                i2cs_pkg::ST_IDLE, i2cs_pkg::ST_WAIT: begin
                    n.sdaOe = 1'b0;
                end
                i2cs_pkg::ST_ADDR, i2cs_pkg::ST_RX: begin
                    if (sclRise) begin
                        n.shift = byteIn; // RULE1
                        n.bitCnt = r.bitCnt + 4'h1;
                        if (r.bitCnt == i2cs_pkg::LAST_BIT) begin
                            n.bitCnt = 4'h0;
                            n.done = 1'b1; // RULE12
                            n.xferDone = 1'b1; // RULE12
                            n.st = i2cs_pkg::ST_ACK_PREP;
                            n.fromAdr = r.st == i2cs_pkg::ST_ADDR;
                            if (r.st == i2cs_pkg::ST_RX) begin
                                n.dataBuf = byteIn; // RULE1
                            end else if (byteIn[7:1] ==
                                         r.slaveAdr[7:1]) begin
                                n.match = 1'b1; // RULE4 RULE13
                                n.mstRd = byteIn[0]; // RULE16
                                n.wakeReq = r.wakeEn; // RULE18
                            end else begin
                                // Another slave is addressed.
                                n.match = 1'b0; // RULE13
                                n.st = i2cs_pkg::ST_WAIT;
                            end
                        end
                    end
                end
                i2cs_pkg::ST_TX: begin
                    if (sclRise) begin
                        n.shift = {r.shift[6:0], 1'b0};
                        n.bitCnt = r.bitCnt + 4'h1;
                        if (r.bitCnt == i2cs_pkg::LAST_BIT) begin
                            n.bitCnt = 4'h0;
                            n.done = 1'b1; // RULE12
                            n.xferDone = 1'b1;
                            n.fromAdr = 1'b0;
                            n.st = i2cs_pkg::ST_ACK_PREP;
                        end
                    end else if (sclFall) begin
                        // Open drain: enable pulls the line low.
                        n.sdaOe = ~r.shift[7];
                    end
                end
                i2cs_pkg::ST_ACK_PREP: begin
                    if (sclFall) begin
                        n.st = i2cs_pkg::ST_ACK;
                        if (r.fromAdr) begin
                            n.sdaOe = 1'b1; // RULE4
                        end else if (r.dirTx) begin
                            // Master owns the line for its ack.
                            n.sdaOe = 1'b0;
                        end else begin
                            n.sdaOe = ~r.txAck; // RULE15
                        end
                    end
                end
                i2cs_pkg::ST_ACK: begin
                    if (sclRise && !r.fromAdr && r.dirTx) begin
                        n.rxAck = sdaIn; // RULE17
                    end else if (sclFall) begin
                        n.bitCnt = 4'h0;
                        if (r.dirTx &&
                            (r.fromAdr || !r.rxAck)) begin
                            n.st = i2cs_pkg::ST_TX; // RULE19
                            n.shift = r.dataBuf; // RULE1
                            n.sdaOe = ~r.dataBuf[7];
                            n.done = 1'b0; // RULE12
                        end else if (r.dirTx) begin
                            // NACK: free the line for STOP.
                            n.st = i2cs_pkg::ST_WAIT; // RULE17
                            n.sdaOe = 1'b0;
                        end else begin
                            n.st = i2cs_pkg::ST_RX; // RULE19
                            n.sdaOe = 1'b0;
                            n.done = 1'b0; // RULE12
                        end
                    end
                end
                default: begin
                    n.st = i2cs_pkg::ST_IDLE;
                    n.sdaOe = 1'b0;
                end
            endcase
        end

        // Synchronous reset overrides everything above.
        if (srst) begin
            n = '0;
            n.dataBuf = i2cs_pkg::DATA_RESET;
            n.slaveAdr = i2cs_pkg::ADR_RESET; // RULE3
            {n.mode, n.debSel, n.enable, n.icf} =
                {i2cs_pkg::CTRL0_RESET[7:5],
                 i2cs_pkg::CTRL0_RESET[3:0]}; // RULE6
            {n.done, n.match, n.busy, n.dirTx,
             n.txAck, n.mstRd, n.wakeEn, n.rxAck} =
                i2cs_pkg::STATUS_RESET; // RULE12
            n.sclPrev = 1'b1;
            n.sdaPrev = 1'b1;
        end
    end

    // ==========
    // State register.
    always_ff @(posedge sys_clk) begin
        r <= n;
    end

    // ==========
    // Outputs come straight from the state register.
    assign prdata   = r.prdata;
    assign pready   = r.pready;
    assign pslverr  = r.pslverr;
    assign sdaOut   = r.sdaOut;
    assign sdaOe    = r.sdaOe;
    assign xferDone = r.xferDone;
    assign wakeReq  = r.wakeReq;
endmodule // i2c_slave_regif
`default_nettype wire

/* logic/i2cs_pkg.sv */
// Shared constants and types for the serial interface slave block.
`default_nettype none
package i2cs_pkg;
    // ==========
    // Register byte offsets.
    localparam logic [11:0] OFS_DATA      = 12'h000;
    localparam logic [11:0] OFS_SLAVE_ADR = 12'h004;
    // The SPI second control register shares the address slot.
    localparam logic [11:0] OFS_SPI_CTL2  = OFS_SLAVE_ADR;
    localparam logic [11:0] OFS_CTRL0     = 12'h008;
    localparam logic [11:0] OFS_STATUS    = 12'h00C;

    // ==========
    // Control register 0 fields.
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 5;
    localparam int DEB_MSB  = 3;
    localparam int DEB_LSB  = 2;
    localparam int EN_BIT   = 1;
    localparam int ICF_BIT  = 0;

    // ==========
    // Bus status and control register fields.
    localparam int DONE_BIT  = 7;
    localparam int MATCH_BIT = 6;
    localparam int BUSY_BIT  = 5;
    localparam int DIR_BIT   = 4;
    localparam int TXACK_BIT = 3;
    localparam int RDWR_BIT  = 2;
    localparam int WAKE_BIT  = 1;
    localparam int RXACK_BIT = 0;

    // ==========
    // Values after reset.
    localparam logic [7:0] CTRL0_RESET  = 8'hE0;
    localparam logic [7:0] STATUS_RESET = 8'h81;
    localparam logic [7:0] ADR_RESET    = 8'h00;
    localparam logic [7:0] DATA_RESET   = 8'h00;

    // ==========
    // Debounce lengths in system clocks and the index of the last bit of a byte.
    localparam logic [2:0] DEB_SHORT = 3'h2;
    localparam logic [2:0] DEB_LONG  = 3'h4;
    localparam logic [3:0] LAST_BIT  = 4'h7;

    // ==========
    // Operating mode field encodings.
    typedef enum logic [2:0] {
        MODE_SPI_DIV4  = 3'h0,
        MODE_SPI_DIV16 = 3'h1,
        MODE_SPI_DIV64 = 3'h2,
        MODE_SPI_SUB   = 3'h3,
        MODE_SPI_TMR   = 3'h4,
        MODE_SPI_SLV   = 3'h5,
        MODE_I2C_SLV   = 3'h6,
        MODE_UNUSED    = 3'h7
    } mode_e;

    // Link engine states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_RX,
        ST_TX,
        ST_ACK_PREP,
        ST_ACK,
        ST_WAIT
    } link_state_e;
endpackage
`default_nettype wire

/* logic/scl_debounce.sv */
// Debounce filter for the serial clock input.
`timescale 1ns/100ps
`default_nettype none
module scl_debounce (
    // Clock and reset.
    input  wire logic     sys_clk,
    input  wire logic     srst,
    // Filter connection.
    scl_filter_if.filter  flt
);
    typedef struct packed {
        logic       level;
        logic [2:0] cnt;
    } deb_s;

    deb_s       r;
    deb_s       n;
    logic [2:0] need;

    // ==========
    // A change is accepted once it has stood for the selected length.
    always_comb begin
        n = r;
        need = flt.debSel[1] ? i2cs_pkg::DEB_LONG :
               flt.debSel[0] ? i2cs_pkg::DEB_SHORT : 3'h0;
        if (!flt.enable) begin
            n.level = 1'b1;
            n.cnt = 3'h0;
        end else if (flt.sclRaw == r.level) begin
            n.cnt = 3'h0;
        end else if (need == 3'h0 || r.cnt + 3'h1 >= need) begin
            n.level = flt.sclRaw; // RULE8
            n.cnt = 3'h0;
        end else begin
            n.cnt = r.cnt + 3'h1;
        end
        if (srst) begin
            n.level = 1'b1;
            n.cnt = 3'h0;
        end
    end

    // State register.
    always_ff @(posedge sys_clk) begin
        r <= n;
    end

    assign flt.sclClean = r.level;
endmodule // scl_debounce
`default_nettype wire

/* logic/scl_filter_if.sv */
// Interface between the register block and the clock line filter.
`timescale 1ns/100ps
`default_nettype none
interface scl_filter_if;
    logic       sclRaw;
    logic [1:0] debSel;
    logic       enable;
    logic       sclClean;
    modport owner  (output sclRaw, debSel, enable, input sclClean);
    modport filter (input sclRaw, debSel, enable, output sclClean);
endinterface
`default_nettype wire

/* testbench/i2c_master_model.sv */
// Behavioural bus master driving the clock and data lines.
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model (
    // Clock.
    input  wire logic sys_clk,
    // Bus lines.
    output logic      sclLine,
    output logic      sdaLow,
    input  wire logic sdaLine
);
    // Half clock period; data moves a quarter in, past the filter lag.
    localparam int HALF = 16;

    // ====
    // Both lines idle high between frames.
    initial begin
        sclLine = 1'b1;
        sdaLow  = 1'b0;
    end

    task automatic ticks(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // One clock: set data while low, sample in mid high.
    task automatic bit_io(input logic b, output logic seen);
        ticks(HALF / 2);
        sdaLow <= !b;
        ticks(HALF / 2);
        sclLine <= 1'b1;
        ticks(HALF / 2);
        seen = sdaLine;
        ticks(HALF / 2);
        sclLine <= 1'b0;
    endtask

    task automatic start();
        sdaLow <= 1'b1;
        ticks(HALF);
        sclLine <= 1'b0;
    endtask

    task automatic stop();
        ticks(HALF / 2);
        sdaLow <= 1'b1;
        ticks(HALF / 2);
        sclLine <= 1'b1;
        ticks(HALF);
        sdaLow <= 1'b0;
        ticks(HALF);
    endtask

    // One-cycle clock spike while low; the debounce must swallow it.
    task automatic spike();
        sclLine <= 1'b1;
        ticks(1);
        sclLine <= 1'b0;
    endtask

    // Eight bits out MSB first, then the slave answer.
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, ack);
    endtask

    // Eight bits in, then our own answer on the ninth clock.
    task automatic read_byte(input logic ackBit, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(ackBit, s);
    endtask
endmodule // i2c_master_model
`default_nettype wire

/* testbench/i2c_slave_regif_asserts.sv */
// Port checker for the serial interface slave.
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_regif_asserts (
    // Clock and reset.
    input wire logic        sys_clk,
    input wire logic        srst,
    // APB side.
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Serial side and events.
    input wire logic        sclIn,
    input wire logic        sdaIn,
    input wire logic        sdaOut,
    input wire logic        sdaOe,
    input wire logic        xferDone,
    input wire logic        wakeReq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    // ====
    // Bus steps as named sequences.
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_start;
        sclIn && $fell(sdaIn);
    endsequence

    // ====
    // Register bus answers.
    a_apb_one_wait: assert property (
        s_setup ##1 s_access |-> !pready ##1 pready)
        else $error("access not answered after one wait");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_idle_rdata: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not zero outside answer");
    a_upper_zero: assert property (
        pready |-> prdata[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error flag without ready");

    // ====
    // Serial line behaviour; the line is only pulled low, never driven high.
    a_open_drain: assert property (sdaOe |-> !sdaOut)
        else $error("data line driven high");
    a_oe_scl_low: assert property (sclIn |-> $stable(sdaOe))
        else $error("data line changed while clock high");
    a_start_quiet: assert property (
        s_start |=> !xferDone [*8])
        else $error("byte done right after start");
    a_done_pulse: assert property (xferDone |=> !xferDone)
        else $error("done pulse longer than one cycle");
    a_wake_match: assert property (
        wakeReq |-> xferDone ##1 !wakeReq)
        else $error("wake pulse malformed");
endmodule // i2c_slave_regif_asserts

bind i2c_slave_regif i2c_slave_regif_asserts u_chk (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .psel     (psel),
    .penable  (penable),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .sclIn    (sclIn),
    .sdaIn    (sdaIn),
    .sdaOut   (sdaOut),
    .sdaOe    (sdaOe),
    .xferDone (xferDone),
    .wakeReq  (wakeReq)
);
`default_nettype wire

/* testbench/i2c_slave_register_interface_tb.sv */
// Self-checking bench for the serial interface slave.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module i2c_slave_register_interface_tb;
    logic        sys_clk, srst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        sdaOut, sdaOe, xferDone, wakeReq, sclLine, sdaLow, ack;
    logic [7:0]  d;
    wire logic   sdaLine;
    int          n_fail, compares, nDone, nWake;

    // Pull-up on the data line; either party may pull it low.
    assign sdaLine = (sdaOe === 1'b1 || sdaLow) ? 1'b0 : 1'b1;

    i2c_slave_regif DUT (.sys_clk(sys_clk), .srst(srst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .xferDone(xferDone), .wakeReq(wakeReq));
    i2c_master_model u_master (.sys_clk(sys_clk), .sclLine(sclLine),
        .sdaLow(sdaLow), .sdaLine(sdaLine));

    // ====
    // Clock and event pulse counters.
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (xferDone === 1'b1) nDone++;
        if (wakeReq === 1'b1) nWake++;
    end

    task automatic end_of_test();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One APB transfer; the request stands until ready is seen high.
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [7:0] wd, output logic [31:0] r,
                       output logic e);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= {24'h0, wd};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            end_of_test();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] wd);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b1, wd, r, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] m, exp);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b0, 8'h00, r, e);
        `CHK(r[7:0] & m, exp)
    endtask

    // ====
    // Scenarios.
    task automatic t_reset_values();
        logic [31:0] r;
        logic        e;
        rd(i2cs_pkg::OFS_DATA, 8'hFF, i2cs_pkg::DATA_RESET);
        rd(i2cs_pkg::OFS_SLAVE_ADR, 8'hFF, 8'h00);
        rd(i2cs_pkg::OFS_CTRL0, 8'hFF, 8'hE0);
        rd(i2cs_pkg::OFS_STATUS, 8'hFF, 8'h81);
        apb(12'h010, 1'b0, 8'h00, r, e);
        `CHK(e, 1'b1)
    endtask

    task automatic t_reg_access();
        wr(i2cs_pkg::OFS_SPI_CTL2, 8'hFF);
        rd(i2cs_pkg::OFS_SLAVE_ADR, 8'hFF, 8'hFF);
        // Bit 4 is absent and must read back as zero.
        for (int m = 0; m < 8; m++) begin
            wr(i2cs_pkg::OFS_CTRL0, {m[2:0], 5'h1D});
            rd(i2cs_pkg::OFS_CTRL0, 8'hFF, {m[2:0], 5'h0D});
        end
        wr(i2cs_pkg::OFS_STATUS, 8'hFF);
        rd(i2cs_pkg::OFS_STATUS, 8'h1A, 8'h1A);
        wr(i2cs_pkg::OFS_STATUS, 8'h00);
    endtask

    task automatic t_receive();
        wr(i2cs_pkg::OFS_SLAVE_ADR, 8'hB4);
        wr(i2cs_pkg::OFS_STATUS, 8'h02);
        wr(i2cs_pkg::OFS_CTRL0, 8'hC2);
        nDone = 0;
        nWake = 0;
        u_master.start();
        rd(i2cs_pkg::OFS_STATUS, 8'hA0, 8'h20);
        u_master.write_byte(8'hB4, ack);
        `CHK(ack, 1'b0)
        `CHK(nWake, 1)
        rd(i2cs_pkg::OFS_STATUS, 8'h64, 8'h60);
        wr(i2cs_pkg::OFS_STATUS, 8'h00);
        u_master.write_byte(8'h3C, ack);
        `CHK(ack, 1'b0)
        rd(i2cs_pkg::OFS_DATA, 8'hFF, 8'h3C);
        wr(i2cs_pkg::OFS_STATUS, 8'h08);
        u_master.write_byte(8'hC3, ack);
        `CHK(ack, 1'b1)
        rd(i2cs_pkg::OFS_DATA, 8'hFF, 8'hC3);
        u_master.stop();
        rd(i2cs_pkg::OFS_STATUS, 8'h60, 8'h00);
        `CHK(nDone, 3)
        wr(i2cs_pkg::OFS_STATUS, 8'h00);
    endtask

    task automatic t_transmit();
        wr(i2cs_pkg::OFS_CTRL0, 8'hC6);
        wr(i2cs_pkg::OFS_DATA, 8'hA5);
        wr(i2cs_pkg::OFS_STATUS, 8'h10);
        u_master.start();
        u_master.write_byte(8'hB5, ack);
        `CHK(ack, 1'b0)
        rd(i2cs_pkg::OFS_STATUS, 8'h44, 8'h44);
        u_master.spike();
        u_master.read_byte(1'b0, d);
        `CHK(d, 8'hA5)
        rd(i2cs_pkg::OFS_STATUS, 8'h01, 8'h00);
        u_master.read_byte(1'b1, d);
        `CHK(d, 8'hA5)
        rd(i2cs_pkg::OFS_STATUS, 8'h01, 8'h01);
        u_master.stop();
    endtask

    task automatic t_ignored(input logic [7:0] ctl, input logic [7:0] adr);
        wr(i2cs_pkg::OFS_CTRL0, ctl);
        u_master.start();
        u_master.write_byte(adr, ack);
        `CHK(ack, 1'b1)
        rd(i2cs_pkg::OFS_STATUS, 8'h40, 8'h00);
        u_master.stop();
        rd(i2cs_pkg::OFS_STATUS, 8'h20, 8'h00);
    endtask

    task automatic t_enable_reset();
        wr(i2cs_pkg::OFS_CTRL0, 8'hC0);
        wr(i2cs_pkg::OFS_STATUS, 8'h18);
        wr(i2cs_pkg::OFS_CTRL0, 8'hC2);
        rd(i2cs_pkg::OFS_STATUS, 8'hFF, 8'h99);
    endtask

    // ====
    // Main sequence: reset for three cycles, then every scenario.
    initial begin
        sys_clk = 1'b0;
        srst    = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        t_reset_values();
        t_reg_access();
        t_receive();
        t_transmit();
        t_ignored(8'hCA, 8'h22);
        t_ignored(8'hC0, 8'hB4);
        t_enable_reset();
        end_of_test();
    end
endmodule // i2c_slave_register_interface_tb
`default_nettype wire
